// ==== hdl/uiic_pkg.sv ====
package uiic_pkg;
   // register byte offsets
   localparam logic [5:0] UIIC_OFS_IER     = 6'h04;
   localparam logic [5:0] UIIC_OFS_IDENT   = 6'h08;
   localparam logic [5:0] UIIC_OFS_RAWPEND = 6'h20;

   // reset values
   localparam logic [7:0] UIIC_IDENT_RESET = 8'h01;
   localparam logic [3:0] UIIC_IER_RESET   = 4'h0;
   localparam logic [1:0] UIIC_TRIG_RESET  = 2'h0;

   // field positions
   localparam int UIIC_FC_EN      = 0;
   localparam int UIIC_FC_RXFL    = 1;
   localparam int UIIC_FC_TXFL    = 2;
   localparam int UIIC_FC_TRIG_LO = 6;
   localparam int UIIC_IE_RDA     = 0;
   localparam int UIIC_IE_THRE    = 1;
   localparam int UIIC_IE_RLS     = 2;
   localparam int UIIC_IE_MSR     = 3;

   // pending source codes, bits 3:1 of the ident register
   localparam logic [2:0] UIIC_CODE_RLS  = 3'h3;
   localparam logic [2:0] UIIC_CODE_RDA  = 3'h2;
   localparam logic [2:0] UIIC_CODE_TO   = 3'h6;
   localparam logic [2:0] UIIC_CODE_THRE = 3'h1;
   localparam logic [2:0] UIIC_CODE_MSR  = 3'h0;

   // receive trigger levels in bytes
   localparam logic [4:0] UIIC_TRIG_L0 = 5'h01;
   localparam logic [4:0] UIIC_TRIG_L1 = 5'h04;
   localparam logic [4:0] UIIC_TRIG_L2 = 5'h08;
   localparam logic [4:0] UIIC_TRIG_L3 = 5'h0E;

   // character timeout counts
   localparam logic [4:0] UIIC_OVERSAMPLE    = 5'h10;
   localparam logic [2:0] UIIC_TIMEOUT_CHARS = 3'h4;

   typedef enum logic [0:0] {
      UIIC_BUS_IDLE = 1'b0,
      UIIC_BUS_ACK  = 1'b1
   } uiic_bus_type;
endpackage : uiic_pkg

// ==== hdl/uiic_top.sv ====
// Local design decision: register access over Avalon-MM.
`timescale 1ns/1ps
module uiic_top
   import uiic_pkg::*;
#(
   parameter int FIFO_DEPTH_BITS = 5
) (
   input  wire logic                       core_clk,
   input  wire logic                       srst,
   // avalon-mm slave
   input  wire logic [5:0]                 avs_address,
   input  wire logic                       avs_read,
   input  wire logic                       avs_write,
   input  wire logic [31:0]                avs_writedata,
   input  wire logic [3:0]                 avs_byteenable,
   output logic      [31:0]                avs_readdata,
   output logic                            avs_waitrequest,
   // events from the rest of the port
   input  wire logic                       overrun_err,
   input  wire logic                       parity_err,
   input  wire logic                       framing_err,
   input  wire logic                       break_det,
   input  wire logic                       line_status_reg_read,
   input  wire logic                       receive_buffer_read,
   input  wire logic                       rx_push,
   input  wire logic [FIFO_DEPTH_BITS-1:0] rx_count,
   input  wire logic                       tx_empty_event,
   input  wire logic                       transmit_holding_write,
   input  wire logic                       modem_change,
   input  wire logic                       modem_status_reg_read,
   input  wire logic                       baud_tick,
   input  wire logic [3:0]                 frame_bits,
   // to the fifos and the interrupt line
   output logic                            fifo_enable_bit,
   output logic      [1:0]                 rx_trigger_select,
   output logic                            tx_fifo_flush,
   output logic                            rx_fifo_flush,
   output logic                            serial_irq_out
);

   typedef struct packed {
      uiic_bus_type bus;
      logic [31:0]  rdata;
      logic [7:0]   ident_snap;
      logic [3:0]   interrupt_enable_reg;
      logic         fen;
      logic [1:0]   trig;
      logic         txfl;
      logic         rxfl;
      logic         rls_pend;
      logic         thre_pend;
      logic         msr_pend;
      logic         to_pend;
      logic [8:0]   baud_cnt;
      logic [2:0]   char_cnt;
      logic         irq;
   } uiic_state_type;

   uiic_state_type st;
   uiic_state_type next_st;

   function automatic logic [4:0] trig_bytes(input logic [1:0] sel);
      case (sel)
         2'h0:    trig_bytes = UIIC_TRIG_L0;
         2'h1:    trig_bytes = UIIC_TRIG_L1;
         2'h2:    trig_bytes = UIIC_TRIG_L2;
         default: trig_bytes = UIIC_TRIG_L3;
      endcase
   endfunction : trig_bytes

   // ident value from gated pending flags, highest priority first
   function automatic logic [7:0] ident_value(
      input logic fen,
      input logic rls,
      input logic rda,
      input logic tmo,
      input logic thre,
      input logic modem_status_reg
   );
      logic [2:0] code;
      logic       none;
      code = 3'h0;
      none = 1'b0;
      if (rls) begin
         code = UIIC_CODE_RLS;
      end else if (rda) begin
         code = UIIC_CODE_RDA;
      end else if (tmo) begin
         code = UIIC_CODE_TO;
      end else if (thre) begin
         code = UIIC_CODE_THRE;
      end else if (modem_status_reg) begin
         code = UIIC_CODE_MSR;
      end else begin
         none = 1'b1;
      end
      ident_value = {{2{fen}}, 2'h0, code, none};
   endfunction : ident_value

   logic             req;
   logic             wr_lo;
   logic [7:0]       wbyte;
   logic [4:0]       rx_level;
   logic             rda_raw;
   logic             en_rls;
   logic             en_rda;
   logic             en_to;
   logic             en_thre;
   logic             en_msr;
   logic [7:0]       ident_now;
   logic [8:0]       char_len;
   logic             rx_traffic;
   logic             any_err;
   logic [4:0]       rx_count_w;

   assign req             = avs_read | avs_write;
   assign wr_lo           = avs_write & avs_byteenable[0];
   assign wbyte           = avs_writedata[7:0];
   assign avs_waitrequest = (st.bus != UIIC_BUS_ACK);
   assign avs_readdata    = st.rdata;

   assign fifo_enable_bit   = st.fen;
   assign rx_trigger_select = st.trig;
   assign tx_fifo_flush     = st.txfl;
   assign rx_fifo_flush     = st.rxfl;
   assign serial_irq_out    = st.irq;

   always_comb begin
      rx_count_w = 5'(rx_count);
      rx_level   = trig_bytes(st.trig);
      // data available: any byte without fifo, trigger level with fifo
      rda_raw    = st.fen ? (rx_count_w >= rx_level) : (rx_count_w != 5'h00);
      en_rda     = rda_raw & st.interrupt_enable_reg[UIIC_IE_RDA];
      en_to      = st.to_pend & st.interrupt_enable_reg[UIIC_IE_RDA];
      en_thre    = st.thre_pend & st.interrupt_enable_reg[UIIC_IE_THRE];
      en_rls     = st.rls_pend & st.interrupt_enable_reg[UIIC_IE_RLS];
      en_msr     = st.msr_pend & st.interrupt_enable_reg[UIIC_IE_MSR];
      ident_now  = ident_value(st.fen, en_rls, en_rda, en_to, en_thre, en_msr);
      char_len   = 9'(frame_bits) * 9'(UIIC_OVERSAMPLE);
      rx_traffic = rx_push | receive_buffer_read | st.rxfl;
      any_err    = overrun_err | parity_err | framing_err | break_det;
   end

   always_comb begin
      next_st      = st;
      next_st.txfl = 1'b0;
      next_st.rxfl = 1'b0;

      // sticky sources: a set in the clearing cycle wins
      if (line_status_reg_read) begin
         next_st.rls_pend = 1'b0;
      end
      if (any_err) begin
         next_st.rls_pend = 1'b1;
      end
      if (modem_status_reg_read) begin
         next_st.msr_pend = 1'b0;
      end
      if (modem_change) begin
         next_st.msr_pend = 1'b1;
      end
      if (transmit_holding_write) begin
         next_st.thre_pend = 1'b0;
      end

      // character timeout: counts only with bytes waiting in fifo mode
      if (rx_traffic || !st.fen || rx_count_w == 5'h00) begin
         next_st.baud_cnt = 9'h000;
         next_st.char_cnt = 3'h0;
      end else if (baud_tick && st.char_cnt != UIIC_TIMEOUT_CHARS) begin
         if (st.baud_cnt + 9'h001 >= char_len) begin
            next_st.baud_cnt = 9'h000;
            next_st.char_cnt = st.char_cnt + 3'h1;
         end else begin
            next_st.baud_cnt = st.baud_cnt + 9'h001;
         end
      end
      if (receive_buffer_read || !st.fen || st.rxfl) begin
         next_st.to_pend = 1'b0;
      end
      if (st.fen && rx_count_w != 5'h00 && st.char_cnt == UIIC_TIMEOUT_CHARS
          && !rx_traffic) begin
         next_st.to_pend = 1'b1;
      end

      case (st.bus)
         UIIC_BUS_IDLE: begin
            if (req) begin
               next_st.bus = UIIC_BUS_ACK;
               // snapshot held until the access completes
               next_st.ident_snap = ident_now;
               case (avs_address)
                  UIIC_OFS_IER: begin
                     next_st.rdata = {28'h0, st.interrupt_enable_reg};
                  end
                  UIIC_OFS_IDENT: begin
                     next_st.rdata = {24'h0, ident_now};
                  end
                  UIIC_OFS_RAWPEND: begin
                     next_st.rdata = {27'h0, st.msr_pend, st.thre_pend, st.to_pend,
                                      rda_raw, st.rls_pend};
                  end
                  default: begin
                     next_st.rdata = 32'h0;
                  end
               endcase
               if (!avs_read) begin
                  next_st.rdata = 32'h0;
               end
            end
         end
         UIIC_BUS_ACK: begin
            next_st.bus = UIIC_BUS_IDLE;
            if (avs_read && avs_address == UIIC_OFS_IDENT
                && st.ident_snap[3:0] == {UIIC_CODE_THRE, 1'b0}
                && !tx_empty_event) begin
               next_st.thre_pend = 1'b0;
            end
            if (wr_lo && avs_address == UIIC_OFS_IER) begin
               next_st.interrupt_enable_reg = wbyte[3:0];
            end
            if (wr_lo && avs_address == UIIC_OFS_IDENT) begin
               next_st.fen = wbyte[UIIC_FC_EN];
               if (wbyte[UIIC_FC_EN] != st.fen) begin
                  next_st.txfl = 1'b1;
                  next_st.rxfl = 1'b1;
               end
               // other bits only take effect alongside the enable bit
               if (wbyte[UIIC_FC_EN]) begin
                  next_st.trig = wbyte[UIIC_FC_TRIG_LO +: 2];
                  if (wbyte[UIIC_FC_TXFL]) begin
                     next_st.txfl = 1'b1;
                  end
                  if (wbyte[UIIC_FC_RXFL]) begin
                     next_st.rxfl = 1'b1;
                  end
               end
            end
         end
         default: begin
            next_st.bus = UIIC_BUS_IDLE;
         end
      endcase

      if (tx_empty_event) begin
         next_st.thre_pend = 1'b1;
      end

      next_st.irq = en_rls | en_rda | en_to | en_thre | en_msr;
   end

   always_ff @(posedge core_clk) begin
      if (srst) begin
         st            <= '0;
         st.bus        <= UIIC_BUS_IDLE;
         st.ident_snap <= UIIC_IDENT_RESET;
         st.interrupt_enable_reg        <= UIIC_IER_RESET;
         st.trig       <= UIIC_TRIG_RESET;
      end else begin
         st <= next_st;
      end
   end

endmodule : uiic_top

// ==== verification/uiic_checker_props.sv ====
`timescale 1ns/1ps
module uiic_checker
   import uiic_pkg::*;
(
   input wire logic        core_clk,
   input wire logic        srst,
   input wire logic [5:0]  avs_address,
   input wire logic        avs_read,
   input wire logic        avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [3:0]  avs_byteenable,
   input wire logic [31:0] avs_readdata,
   input wire logic        avs_waitrequest,
   input wire logic        fifo_enable_bit,
   input wire logic [1:0]  rx_trigger_select,
   input wire logic        tx_fifo_flush,
   input wire logic        rx_fifo_flush
);
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (srst);
   wire rd8 = !avs_waitrequest && avs_read && avs_address == UIIC_OFS_IDENT;
   wire wr8 = !avs_waitrequest && avs_write && avs_address == UIIC_OFS_IDENT && avs_byteenable[0];

   a_ack_single: assert property (!avs_waitrequest |=> avs_waitrequest)
      else $error("ack held more than one cycle");
   a_ack_prompt: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
      else $error("request not acked after one wait");
   a_ident_high: assert property (rd8 |-> avs_readdata[7:6] == {2{fifo_enable_bit}})
      else $error("ident bits 7:6 differ from fifo enable");
   a_ident_zero: assert property (rd8 |-> avs_readdata[5:4] == 2'h0 && avs_readdata[31:8] == 24'h0)
      else $error("ident zero bits set");
   a_idle_code: assert property (rd8 && avs_readdata[0] |-> avs_readdata[3:1] == 3'h0)
      else $error("code bits set with nothing pending");
   a_code_bit3: assert property (rd8 && !fifo_enable_bit |-> !avs_readdata[3])
      else $error("ident bit 3 set outside fifo mode");
   a_fen_write: assert property (wr8 |=> fifo_enable_bit == $past(avs_writedata[0]))
      else $error("fifo enable not taken from write");
   a_trig_hold: assert property (wr8 && !avs_writedata[0] |=> $stable(rx_trigger_select))
      else $error("trigger changed by write with enable clear");
   a_trig_set: assert property (wr8 && avs_writedata[0] |=> rx_trigger_select == $past(avs_writedata[7:6]))
      else $error("trigger select not taken from write");
   a_mode_flush: assert property ($changed(fifo_enable_bit) |-> tx_fifo_flush && rx_fifo_flush)
      else $error("mode switch without flush");
   a_tx_flush: assert property (tx_fifo_flush |-> $past(wr8) ##1 !tx_fifo_flush)
      else $error("tx flush not a single pulse after write");
   a_rx_flush: assert property (wr8 && avs_writedata[1:0] == 2'h3 |=> rx_fifo_flush ##1 !rx_fifo_flush)
      else $error("rx flush not a single pulse");
endmodule : uiic_checker

bind uiic_top uiic_checker u_chk (.core_clk, .srst, .avs_address, .avs_read, .avs_write,
   .avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest, .fifo_enable_bit,
   .rx_trigger_select, .tx_fifo_flush, .rx_fifo_flush);

// ==== verification/uiic_host_model.sv ====
`timescale 1ns/1ps
module uiic_host_model (
   input  wire logic        core_clk,
   output logic [5:0]       avs_address,
   output logic             avs_read,
   output logic             avs_write,
   output logic [31:0]      avs_writedata,
   output logic [3:0]       avs_byteenable,
   input  wire logic [31:0] avs_readdata,
   input  wire logic        avs_waitrequest
);
   initial begin
      avs_address = 6'h00; avs_read = 1'b0; avs_write = 1'b0;
      avs_writedata = 32'h0; avs_byteenable = 4'hF;
   end
   // writes to 0x08 reach fifo control, reads return ident
   task automatic acc(input logic w, input logic [5:0] a, input logic [7:0] d,
                      output logic [31:0] q);
      int n;
      n = 0;
      @(posedge core_clk);
      avs_read <= !w; avs_write <= w; avs_address <= a; avs_writedata <= {24'h0, d};
      do begin
         @(posedge core_clk);
         n++;
      end while (avs_waitrequest !== 1'b0);
      q = avs_readdata;
      // released lines do not keep the last value
      avs_read <= 1'b0; avs_write <= 1'b0; avs_address <= ~a; avs_writedata <= ~{24'h0, d};
   endtask : acc
endmodule : uiic_host_model

// ==== verification/uiic_top_test.sv ====
`timescale 1ns/1ps
module uiic_top_test
   import uiic_pkg::*;
;
   logic core_clk = 1'b0, srst = 1'b1, baud_tick = 1'b1;
   logic [5:0] avs_address;
   logic avs_read, avs_write, avs_waitrequest, fen, txf, rxf, irq;
   logic [31:0] avs_writedata, avs_readdata, q;
   logic [3:0] avs_byteenable;
   logic [10:0] ev = 11'h0;
   logic [4:0] rx_count = 5'h0;
   logic [1:0] trig;
   int miscompares = 0, n_checks = 0;
   always #5 core_clk = ~core_clk;

   uiic_host_model host (.core_clk, .avs_address, .avs_read, .avs_write, .avs_writedata,
      .avs_byteenable, .avs_readdata, .avs_waitrequest);
   uiic_top DUT (.core_clk, .srst, .avs_address, .avs_read, .avs_write, .avs_writedata,
      .avs_byteenable, .avs_readdata, .avs_waitrequest, .overrun_err(ev[0]),
      .parity_err(ev[1]), .framing_err(ev[2]), .break_det(ev[3]),
      .line_status_reg_read(ev[4]), .receive_buffer_read(ev[5]), .rx_push(ev[6]), .rx_count,
      .tx_empty_event(ev[7]), .transmit_holding_write(ev[8]), .modem_change(ev[9]),
      .modem_status_reg_read(ev[10]), .baud_tick, .frame_bits(4'h1),
      .fifo_enable_bit(fen), .rx_trigger_select(trig), .tx_fifo_flush(txf),
      .rx_fifo_flush(rxf), .serial_irq_out(irq));

   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      n_checks++;
      if (g !== e) begin
         miscompares++;
         $display("wrong value %s expected %h seen %h", nm, e, g);
      end
   endtask : chk
   task automatic rd(input logic [5:0] a, input logic [7:0] e);
      host.acc(1'b0, a, 8'h00, q);
      chk("readdata", {24'h0, e}, q);
   endtask : rd
   // the write lands at the ack edge; let one edge pass so registers have settled
   task automatic wr(input logic [5:0] a, input logic [7:0] d);
      host.acc(1'b1, a, d, q);
      @(posedge core_clk);
   endtask : wr
   // pulse, then two edges so pending and irq have settled
   task automatic pulse(input logic [10:0] m);
      @(posedge core_clk) ev <= m;
      @(posedge core_clk) ev <= 11'h0;
      @(posedge core_clk);
   endtask : pulse
   task automatic tally_and_finish;
      $display("checks %0d mismatches %0d", n_checks, miscompares);
      if (miscompares == 0 && n_checks > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask : tally_and_finish

   initial begin
      repeat (20) @(posedge core_clk);
      srst <= 1'b0;
      rd(UIIC_OFS_IDENT, 8'h01);
      rd(UIIC_OFS_IER, 8'h00);
      rd(6'h10, 8'h00);
      pulse(11'h080);
      rd(UIIC_OFS_IDENT, 8'h01);
      chk("irq", 0, irq);
      wr(UIIC_OFS_IER, 8'h0F);
      rd(UIIC_OFS_IER, 8'h0F);
      @(posedge core_clk);
      chk("irq", 1, irq);
      rd(UIIC_OFS_IDENT, 8'h02);
      rd(UIIC_OFS_IDENT, 8'h01);
      chk("irq", 0, irq);
      for (int i = 0; i < 4; i++) begin
         pulse(11'h001 << i);
         rd(UIIC_OFS_IDENT, 8'h06);
         pulse(11'h010);
         rd(UIIC_OFS_IDENT, 8'h01);
      end
      rx_count <= 5'h01;
      pulse(11'h281);
      rd(UIIC_OFS_IDENT, 8'h06);
      rd(UIIC_OFS_IDENT, 8'h06);
      pulse(11'h010);
      rd(UIIC_OFS_IDENT, 8'h04);
      rx_count <= 5'h00;
      @(posedge core_clk);
      rd(UIIC_OFS_IDENT, 8'h02);
      pulse(11'h100);
      rd(UIIC_OFS_IDENT, 8'h00);
      pulse(11'h400);
      rd(UIIC_OFS_IDENT, 8'h01);
      for (int t = 0; t < 4; t++) begin
         wr(UIIC_OFS_IDENT, {t[1:0], 6'h07});
         chk("trigger", t, trig);
         chk("fifo enable", 1, fen);
      end
      wr(UIIC_OFS_IDENT, 8'h40);
      chk("trigger", 3, trig);
      chk("fifo enable", 0, fen);
      wr(UIIC_OFS_IDENT, 8'hC1);
      rd(UIIC_OFS_IDENT, 8'hC1);
      rx_count <= 5'h01;
      pulse(11'h040);
      repeat (80) @(posedge core_clk);
      rd(UIIC_OFS_IDENT, 8'hCC);
      pulse(11'h020);
      rd(UIIC_OFS_IDENT, 8'hC1);
      rx_count <= 5'h0D;
      rd(UIIC_OFS_IDENT, 8'hC1);
      rx_count <= 5'h0E;
      rd(UIIC_OFS_IDENT, 8'hC4);
      rx_count <= 5'h00;
      rd(UIIC_OFS_IDENT, 8'hC1);
      tally_and_finish();
   end
   initial begin
      repeat (20000) @(posedge core_clk);
      miscompares++;
      tally_and_finish();
   end
endmodule : uiic_top_test
